// ==== logic/mtwt_defines.svh ====
// Constants for the memory trace walking tester
`ifndef MTWT_DEFINES_SVH
`define MTWT_DEFINES_SVH
`define MTWT_DATA_W 8
`define MTWT_ADDR_W 8
`define MTWT_DATA_TEST_ADDR 8'h00
`define MTWT_JTAG_BOOT_SEL 3'h7
`define MTWT_SEL_W 3
`define MTWT_ROUTE_W 2
`define MTWT_ROUTE_OFF 2'h0
`define MTWT_ROUTE_PINS 2'h1
`define MTWT_ROUTE_CHAIN 2'h2
`define MTWT_READ_LAT 2'h2
`endif

// ==== logic/mtwt_pkg.sv ====
// Types for the memory trace walking tester
package mtwt_pkg;
`include "mtwt_defines.svh"
   // Memory request toward the external memory
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [`MTWT_ADDR_W-1:0] addr;
      logic [`MTWT_DATA_W-1:0] wrData;
   } mtwt_mem_req_t;
   // Test result bundle
   typedef struct packed {
      logic done;
      logic pass;
      logic bitFail;
      logic [`MTWT_DATA_W-1:0] failBits;
   } mtwt_result_t;
   // Tester states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DWR = 7'h02,
      ST_DRD = 7'h04,
      ST_AWR = 7'h08,
      ST_ARD = 7'h10,
      ST_WAIT = 7'h20,
      ST_DONE = 7'h40
   } mtwt_state_t;
endpackage : mtwt_pkg

// ==== logic/mtwt_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module mtwt_sync #(parameter int W = 1) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Sync reset
   input wire logic [W-1:0] din, // Asynchronous input
   output logic [W-1:0] dout // Synchronised output
);
   logic [W-1:0] meta_ff; // First stage, read only by second
   logic [W-1:0] sync_ff; // Second stage
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;
   // Next values
   always_comb begin
      nxt_meta = din;
      nxt_sync = meta_ff;
      if (rst) begin
         nxt_meta = '0;
         nxt_sync = '0;
      end
   end
   // Register stages
   always_ff @(posedge ref_clk) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
   end
   assign dout = sync_ff;
endmodule : mtwt_sync

// ==== logic/mtwt_tester.sv ====
// Memory trace walking tester with boot and debug route selection
`timescale 1ns/1ns
`include "mtwt_defines.svh"
// Overview of the two test phases
// The data phase walks a single one across every data line at one address.
// Each step is a write, a read and a compare before the next step starts.
// A mismatch is recorded and the walk moves on, so a dead trace cannot hang the run.
// The address phase writes every power-of-two location first, then reads them all.
// Each location holds its index plus one, so an alias returns a foreign value.
// Address index zero stands for address zero, index k for a one in bit k-1.
// Failing bits gather as the OR of every read-back difference of the run.
// The pass flag drops on the first mismatch and stays low until the next start.
// Hazard: the memory answers after any latency, so every read waits for valid.
// Hazard: read data that arrives outside a wait is ignored on purpose.
// The strap and route pins come from the board and are synchronised first.
// The boot strap is frozen once per reset, later strap changes are ignored.
// The debug route follows its pins, gated by the loader and configuration done.
// Route code three is not a setting of its own and is treated as off.
module mtwt_tester
   import mtwt_pkg::*;
(
   input wire logic ref_clk, // Memory interface clock
   input wire logic rst, // Sync reset, active high
   input wire logic start, // Start pulse from same domain
   input wire logic [`MTWT_DATA_W-1:0] memRdData, // Read data from memory
   input wire logic memRdValid, // Read data valid pulse
   input wire logic [`MTWT_SEL_W-1:0] boot_source_select_pins, // Boot strap pins
   input wire logic [`MTWT_ROUTE_W-1:0] debug_port_route_select, // Debug route setting
   input wire logic first_stage_loader_done, // Loader finished pin muxing (pin)
   input wire logic configuration_manager_done, // Configuration complete (pin)
   output mtwt_mem_req_t memReq, // Memory request
   output mtwt_result_t result, // Test result
   output logic [`MTWT_DATA_W-1:0] lastWritten, // Word of the current step
   output logic inAddrTest, // High in address phase
   output logic jtagBoot, // Boot from JTAG
   output logic dbgPinsEn, // Debug port on dedicated pins
   output logic dbgChainEn, // Debug tap first in chain
   output logic chainShift // Chain indices shifted by one
);
   // Fixed widths of the memory interface
   localparam int DW = `MTWT_DATA_W; // Data bus width
   localparam int AW = `MTWT_ADDR_W; // Address bus width
   localparam int BITW = $clog2(AW + 1); // Address index width, counts 0 to AW

   // Power-of-two address for an index; index 0 gives address zero
   // Used by both the write pass and the read pass, so both walk the same list
   function automatic logic [AW-1:0] addrOf(input logic [BITW-1:0] idx);
      logic [AW-1:0] a;
      a = '0;
      if (idx != '0) begin
         a = AW'(1) << (idx - BITW'(1));
      end
      return a;
   endfunction : addrOf

   // Distinct increasing value per address index
   // Never zero, so a cleared location cannot match by chance
   function automatic logic [DW-1:0] valOf(input logic [BITW-1:0] idx);
      return DW'(idx) + DW'(1);
   endfunction : valOf

   // Synchronised pin inputs
   // Straps, route and done levels come from the board, two flip-flops each
   // Nothing below reads a pin directly, only the second stage
   logic [`MTWT_SEL_W-1:0] selSync; // Boot strap, synchronised
   logic [`MTWT_ROUTE_W-1:0] routeSync; // Route setting, synchronised
   logic [1:0] doneSync; // Loader and configuration done
   mtwt_sync #(.W(`MTWT_SEL_W)) u_sel (.ref_clk(ref_clk), .rst(rst),
      .din(boot_source_select_pins), .dout(selSync));
   mtwt_sync #(.W(`MTWT_ROUTE_W)) u_route (.ref_clk(ref_clk), .rst(rst),
      .din(debug_port_route_select), .dout(routeSync));
   mtwt_sync #(.W(2)) u_done (.ref_clk(ref_clk), .rst(rst),
      .din({configuration_manager_done, first_stage_loader_done}), .dout(doneSync));

   // Tester state
   // One process computes next values, one registers them
   mtwt_state_t state_ff, nxt_state; // Main state
   mtwt_state_t ret_ff, nxt_ret; // Read state that issued the pending read, picks the phase after the wait
   logic [DW-1:0] pat_ff, nxt_pat; // Walking-one pattern
   logic [BITW-1:0] idx_ff, nxt_idx; // Address index
   logic down_ff, nxt_down; // Walk direction, captured at start
   mtwt_mem_req_t req_ff, nxt_req; // Registered memory request
   mtwt_result_t res_ff, nxt_res; // Registered result
   logic [DW-1:0] exp_ff, nxt_exp; // Expected read word
   logic addrPh_ff, nxt_addrPh; // Address phase flag
   logic walkDown; // Walk direction, held upward; downward stays in the logic
   logic [DW-1:0] firstPat; // Start pattern for chosen direction
   logic [DW-1:0] diff; // Differing bits of a read-back

   // Direction is fixed upward; only a one in bit 0 starts the walk
   assign walkDown = 1'b0;
   // Start word: top bit for a downward walk, bottom bit for an upward one
   assign firstPat = walkDown ? {1'b1, {(DW-1){1'b0}}} : DW'(1);
   // Bits that differ between the returned word and the expected word
   assign diff = memRdData ^ exp_ff;

   // Next-state logic of the tester
   // Requests and the fail flag are one-cycle pulses, so they drop by default
   // Address and write data keep their last value between requests
   // Reset is applied last so it overrides every branch above it
   always_comb begin
      nxt_state = state_ff;
      nxt_ret = ret_ff;
      nxt_pat = pat_ff;
      nxt_idx = idx_ff;
      nxt_down = down_ff;
      nxt_req = req_ff;
      nxt_res = res_ff;
      nxt_exp = exp_ff;
      nxt_addrPh = addrPh_ff;
      nxt_req.wrEn = 1'b0;
      nxt_req.rdEn = 1'b0;
      nxt_res.bitFail = 1'b0;
      unique case (state_ff)
         ST_IDLE, ST_DONE: begin
            // Start a new run
            // A start while a run is busy never reaches this branch
            if (start) begin
               nxt_down = walkDown;
               nxt_pat = firstPat;
               nxt_res = '0;
               nxt_res.pass = 1'b1;
               nxt_addrPh = 1'b0;
               nxt_state = ST_DWR;
            end
         end
         ST_DWR: begin
            // Write the walking word to the fixed address
            // The same address for every step keeps address faults out of the data result
            nxt_req.wrEn = 1'b1;
            nxt_req.addr = `MTWT_DATA_TEST_ADDR;
            nxt_req.wrData = pat_ff;
            nxt_exp = pat_ff;
            nxt_state = ST_DRD;
         end
         ST_DRD: begin
            // Read it back from the same address
            // The return state tells the wait which phase to resume
            nxt_req.rdEn = 1'b1;
            nxt_req.addr = `MTWT_DATA_TEST_ADDR;
            nxt_ret = ST_DRD;
            nxt_state = ST_WAIT;
         end
         ST_AWR: begin
            // Write a distinct value to each power-of-two address
            // No read is issued until the last location has been written
            nxt_req.wrEn = 1'b1;
            nxt_req.addr = addrOf(idx_ff);
            nxt_req.wrData = valOf(idx_ff);
            if (idx_ff == BITW'(AW)) begin
               nxt_idx = '0;
               nxt_state = ST_ARD;
            end else begin
               nxt_idx = idx_ff + BITW'(1);
            end
         end
         ST_ARD: begin
            // Read back one location
            // The expected word is rebuilt from the index, never taken from memory
            nxt_req.rdEn = 1'b1;
            nxt_req.addr = addrOf(idx_ff);
            nxt_exp = valOf(idx_ff);
            nxt_ret = ST_ARD;
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            // Compare the returned word
            // Any read latency is accepted; the state holds until valid arrives
            // A memory that never answers leaves the tester here, seen as no done
            if (memRdValid) begin
               if (diff != '0) begin
                  nxt_res.bitFail = 1'b1;
                  nxt_res.pass = 1'b0;
                  nxt_res.failBits = res_ff.failBits | diff;
               end
               if (ret_ff == ST_DRD) begin
                  // Advance the walk once the step has been checked
                  // The top bit closes the data phase, any other bit shifts on
                  if ((!down_ff && pat_ff[DW-1]) || (down_ff && pat_ff[0])) begin
                     nxt_addrPh = 1'b1;
                     nxt_idx = '0;
                     nxt_state = ST_AWR;
                  end else begin
                     nxt_pat = down_ff ? (pat_ff >> 1) : (pat_ff << 1);
                     nxt_state = ST_DWR;
                  end
               end else if (idx_ff == BITW'(AW)) begin
                  // Last location checked, the run is over
                  nxt_res.done = 1'b1;
                  nxt_state = ST_DONE;
               end else begin
                  nxt_idx = idx_ff + BITW'(1);
                  nxt_state = ST_ARD;
               end
            end
         end
         default: begin
            // An illegal state code falls back to idle rather than locking up
            nxt_state = ST_IDLE;
         end
      endcase
      // Synchronous reset clears the tester and its outputs
      if (rst) begin
         nxt_state = ST_IDLE;
         nxt_ret = ST_IDLE;
         nxt_pat = '0;
         nxt_idx = '0;
         nxt_down = 1'b0;
         nxt_req = '0;
         nxt_res = '0;
         nxt_exp = '0;
         nxt_addrPh = 1'b0;
      end
   end

   // Register the tester state
   // Only plain registering here; all decisions sit in the process above
   always_ff @(posedge ref_clk) begin
      state_ff <= nxt_state;
      ret_ff <= nxt_ret;
      pat_ff <= nxt_pat;
      idx_ff <= nxt_idx;
      down_ff <= nxt_down;
      req_ff <= nxt_req;
      res_ff <= nxt_res;
      exp_ff <= nxt_exp;
      addrPh_ff <= nxt_addrPh;
   end

   // Boot and debug route state
   // The strap is frozen a fixed number of edges after reset, once the
   // synchroniser holds the pin level instead of its own reset zeros
   logic jtag_ff, nxt_jtag; // JTAG boot selected
   logic pins_ff, nxt_pins; // Debug on dedicated pins
   logic chain_ff, nxt_chain; // Debug tap in chain
   logic shift_ff, nxt_shift; // Chain index shifted
   logic strapTaken_ff, nxt_strapTaken; // Strap captured once after reset
   logic [1:0] strapWait_ff, nxt_strapWait; // Fills with ones while the strap synchroniser settles

   // Next values for boot source and debug routing
   always_comb begin
      nxt_jtag = jtag_ff;
      nxt_strapTaken = strapTaken_ff;
      // Two edges after reset the synchronised strap is the pin level
      nxt_strapWait = {strapWait_ff[0], 1'b1};
      if (strapWait_ff[1] && !strapTaken_ff) begin
         // Capture once; later strap changes wait for the next reset
         nxt_jtag = (selSync == `MTWT_JTAG_BOOT_SEL);
         nxt_strapTaken = 1'b1;
      end
      // Route code for off and the unused code both leave every route low
      // Dedicated pins only once the loader has set up the pin multiplexing
      nxt_pins = (routeSync == `MTWT_ROUTE_PINS) && doneSync[0];
      // Chained tap only once configuration is complete
      nxt_chain = (routeSync == `MTWT_ROUTE_CHAIN) && doneSync[1];
      // The joined tap sits first, so every other index moves up by one
      nxt_shift = nxt_chain;
      if (rst) begin
         nxt_jtag = 1'b0;
         nxt_strapTaken = 1'b0;
         nxt_strapWait = 2'h0;
         nxt_pins = 1'b0;
         nxt_chain = 1'b0;
         nxt_shift = 1'b0;
      end
   end

   // Register boot and debug routing
   always_ff @(posedge ref_clk) begin
      jtag_ff <= nxt_jtag;
      pins_ff <= nxt_pins;
      chain_ff <= nxt_chain;
      shift_ff <= nxt_shift;
      strapTaken_ff <= nxt_strapTaken;
      strapWait_ff <= nxt_strapWait;
   end

   // Outputs straight from flip-flops
   // Every port below is a register, so the far side sees no combinational glitches
   // lastWritten shows the word that the current compare expects
   assign memReq = req_ff;
   assign result = res_ff;
   assign lastWritten = exp_ff;
   assign inAddrTest = addrPh_ff;
   assign jtagBoot = jtag_ff;
   assign dbgPinsEn = pins_ff;
   assign dbgChainEn = chain_ff;
   assign chainShift = shift_ff;
endmodule : mtwt_tester

// ==== dv/mtwt_mem_model.sv ====
// Behavioural memory chip on the far side of the tester
`timescale 1ns/1ns
module mtwt_mem_model
   import mtwt_pkg::*;
(
   input wire logic ref_clk, // Clock
   input mtwt_mem_req_t memReq, // Request from tester
   input wire logic [3:0] lat, // Read latency, 1 or more
   input wire logic [7:0] stuckLo, // Data traces stuck low
   input wire logic [7:0] addrLo, // Address traces stuck low
   output logic [7:0] memRdData = 8'h5a, // Read word
   output logic memRdValid = 1'b0 // Read valid pulse
);
   logic [7:0] mem [256]; // Storage
   logic [7:0] word; // Pending read word
   int cnt = 0; // Cycles to the answer
   // Stuck address traces hit writes and reads, stuck data traces only writes; idle data toggles so no stale word is seen
   always @(posedge ref_clk) begin
      memRdValid <= 1'b0;
      memRdData <= ~memRdData;
      if (memReq.wrEn) mem[memReq.addr & ~addrLo] <= memReq.wrData & ~stuckLo;
      if (memReq.rdEn) begin
         word <= mem[memReq.addr & ~addrLo];
         cnt <= int'(lat);
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            memRdValid <= 1'b1;
            memRdData <= word;
         end
      end
   end
endmodule : mtwt_mem_model

// ==== dv/mtwt_tester_assertions.sv ====
// Concurrent checks on the tester ports
`timescale 1ns/1ns
module mtwt_chk
   import mtwt_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic rst, // Sync reset
   input wire logic [7:0] memRdData, // Read word
   input wire logic memRdValid, // Read valid
   input wire logic [2:0] boot_source_select_pins, // Straps
   input mtwt_mem_req_t memReq, // Request
   input mtwt_result_t result, // Result
   input wire logic [7:0] lastWritten, // Step word
   input wire logic inAddrTest, // Address phase
   input wire logic jtagBoot, // JTAG boot
   input wire logic dbgPinsEn, // Pin route
   input wire logic dbgChainEn, // Chain route
   input wire logic chainShift // Index shift
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic rdSeen_ff; // Address phase has begun reading
   logic nxt_rdSeen; // Next value
   // Remember the first address read until the phase ends
   always_comb nxt_rdSeen = inAddrTest && (rdSeen_ff || memReq.rdEn);
   always_ff @(posedge ref_clk) rdSeen_ff <= !rst && nxt_rdSeen;
   sequence wrStep; memReq.wrEn && !inAddrTest; endsequence
   sequence rdStep; memReq.rdEn && memReq.addr == 8'h00; endsequence
   one_hot_a: assert property (wrStep |-> $onehot(memReq.wrData))
      else $error("data word not one-hot");
   fixed_addr_a: assert property (wrStep |-> memReq.addr == 8'h00)
      else $error("data address moved");
   wr_rd_pair_a: assert property (wrStep |=> rdStep)
      else $error("no read after write");
   fail_seen_a: assert property (memRdValid && memRdData != lastWritten |=> result.bitFail)
      else $error("mismatch not flagged");
   addr_pow2_a: assert property (inAddrTest && memReq.wrEn |-> $countones(memReq.addr) <= 1)
      else $error("address not power of two");
   wr_before_rd_a: assert property (rdSeen_ff |-> !memReq.wrEn)
      else $error("write after read");
   addr_value_a: assert property (inAddrTest && memReq.wrEn |-> memReq.wrData ==
      (memReq.addr == 8'h00 ? 8'h01 : 8'($clog2(memReq.addr)) + 8'h02))
      else $error("address value wrong");
   jtag_boot_a: assert property ($rose(jtagBoot) |-> $past(boot_source_select_pins, 3) == 3'h7)
      else $error("jtag boot without strap");
   route_excl_a: assert property (!(dbgPinsEn && dbgChainEn) && chainShift == dbgChainEn)
      else $error("debug route clash");
endmodule : mtwt_chk
bind mtwt_tester mtwt_chk i_chk (.ref_clk(ref_clk), .rst(rst), .memRdData(memRdData),
   .memRdValid(memRdValid), .boot_source_select_pins(boot_source_select_pins), .memReq(memReq),
   .result(result), .lastWritten(lastWritten), .inAddrTest(inAddrTest), .jtagBoot(jtagBoot),
   .dbgPinsEn(dbgPinsEn), .dbgChainEn(dbgChainEn), .chainShift(chainShift));

// ==== dv/mtwt_tester_tb.sv ====
// Self-checking bench for the memory trace walking tester
`timescale 1ns/1ns
module mtwt_tester_tb;
   import mtwt_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0; // Clock, reset, start
   logic [2:0] bootPins = 3'h7; // Boot straps
   logic [1:0] route = 2'h0; // Debug route
   logic ldDone = 1'b0, cfgDone = 1'b0; // Loader, configuration done
   logic [7:0] memRdData, stuckLo = 8'h00, addrLo = 8'h00; // Read word, faults
   logic memRdValid; // Read valid
   logic [3:0] lat = 4'h1; // Memory latency
   mtwt_mem_req_t memReq; // Request
   mtwt_result_t result; // Result
   logic jtagBoot, dbgPinsEn, dbgChainEn, chainShift; // Selections
   int fail_count = 0, comparisons = 0, cyc = 0, nFail = 0, seen = 0; // Counters
   logic [31:0] rs = 32'd2990; // Random state
   logic [17:0] q[$], reqExp; // Expected requests
   logic [7:0] sh [256], ff; // Shadow memory, expected fail bits
   initial forever #4 ref_clk = ~ref_clk;
   mtwt_tester i_dut (.ref_clk(ref_clk), .rst(rst), .start(start), .memRdData(memRdData),
      .memRdValid(memRdValid), .boot_source_select_pins(bootPins), .debug_port_route_select(route),
      .first_stage_loader_done(ldDone), .configuration_manager_done(cfgDone), .memReq(memReq),
      .result(result), .lastWritten(), .inAddrTest(), .jtagBoot(jtagBoot), .dbgPinsEn(dbgPinsEn),
      .dbgChainEn(dbgChainEn), .chainShift(chainShift));
   mtwt_mem_model i_mem (.ref_clk(ref_clk), .memReq(memReq), .lat(lat), .stuckLo(stuckLo),
      .addrLo(addrLo), .memRdData(memRdData), .memRdValid(memRdValid));
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic chk(string n, logic [17:0] e, logic [17:0] g);
      comparisons++;
      if (e !== g) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic final_report();
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   // Timeout, request order and fail pulse count, sampled on the falling edge where outputs are settled
   always @(negedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
      if (!rst && result.bitFail) seen++;
      if (!rst && (memReq.wrEn || memReq.rdEn)) begin
         reqExp = q.size() ? q.pop_front() : 18'h3ffff;
         chk("req", reqExp, memReq.rdEn ? {memReq[17:8], reqExp[7:0]} : 18'(memReq));
      end
   end
   // One full test with the given faulty traces, checked against the model
   task automatic run(logic [7:0] sl, logic [7:0] al);
      logic [7:0] a, w;
      stuckLo = sl;
      addrLo = al;
      lat = 4'(1 + rnd() % 4);
      ff = 8'h00;
      nFail = 0;
      seen = 0;
      for (int i = 0; i < 8; i++) begin
         w = 8'h01 << i;
         q.push_back({2'b10, 8'h00, w});
         q.push_back({2'b01, 8'h00, w});
         ff |= w & sl;
         nFail += int'((w & sl) != 8'h00);
      end
      for (int k = 0; k < 18; k++) begin
         a = (k % 9) ? 8'h01 << (k % 9 - 1) : 8'h00;
         w = 8'(k % 9 + 1);
         q.push_back({k < 9 ? 2'b10 : 2'b01, a, w});
         if (k < 9) sh[a & ~al] = w & ~sl;
         else begin
            ff |= sh[a & ~al] ^ w;
            nFail += int'(sh[a & ~al] != w);
         end
      end
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(12);
      start = 1'b1;
      tick(1);
      start = 1'b0;
      for (int n = 0; n < 3000 && result.done !== 1'b1; n++) tick(1);
      tick(2);
      chk("done", 18'h1, {17'h0, result.done});
      chk("pass", {17'h0, ff == 8'h00}, {17'h0, result.pass});
      chk("failBits", {10'h0, ff}, {10'h0, result.failBits});
      chk("bitFail", 18'(nFail), 18'(seen));
      chk("left", 18'h0, 18'(q.size()));
   endtask : run
   initial begin
      tick(10);
      rst = 1'b0;
      tick(4);
      chk("jtagBoot", 18'h1, {17'h0, jtagBoot});
      bootPins = 3'h3;
      run(8'h00, 8'h00);
      run(8'h02, 8'h00);
      run(8'h00, 8'h02);
      run(8'(rnd()), 8'h00);
      chk("jtagBoot", 18'h1, {17'h0, jtagBoot});
      rst = 1'b1;
      tick(3);
      rst = 1'b0;
      tick(4);
      chk("jtagBoot", 18'h0, {17'h0, jtagBoot});
      run(8'h80, 8'h80);
      for (int r = 0; r < 16; r++) begin
         route = 2'(r >> 2);
         ldDone = r[0];
         cfgDone = r[1];
         tick(5);
         chk("dbgPins", {17'h0, r >> 2 == 1 && r[0]}, {17'h0, dbgPinsEn});
         chk("dbgChain", {17'h0, r >> 2 == 2 && r[1]}, {17'h0, dbgChainEn});
         chk("chainShift", {17'h0, r >> 2 == 2 && r[1]}, {17'h0, chainShift});
      end
      final_report();
   end
endmodule : mtwt_tester_tb
